/* File: rtl/loop_cmd_map.svh */
/*
 * constants for the loop device command interpreter.
 * assumes inclusion by bare name from the design file.
 */
`ifndef LOOP_CMD_MAP_SVH
`define LOOP_CMD_MAP_SVH
`define DDL_SET_CTRL 5'h00
`define DDL_CLR_TX 5'h01
`define DDL_SET_CHAR 5'h02
`define DDL_BREAK_ON 5'h03
`define DDL_BREAK_OFF 5'h04
`define DDT_SEND_CTRL 5'h00
`define DDT_CLR_RX 5'h01
`define DDT_SEND_CHAR 5'h02
`define NUM_CTRL 5'h0E
`define NUM_CHAR 5'h0C
`define LAST_CTRL 5'h0D
`define LAST_CHAR 5'h0B
`define CTRL_READ_HI 4'h3
`define CTRL_DEFAULT 4'h0
`define CHAR_DEFAULT 8'h00
`define IDX_ZERO 5'h00
`define IDX_ONE 5'h01
`endif

/* File: rtl/loop_cmd_pkg.sv */
/*
 * types shared by the loop device command interpreter.
 * assumes the map header sits beside it.
 */
package loop_cmd_pkg;
    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_CTRL = 2'b01,
        WR_CHAR = 2'b10
    } wr_sel_t;
    typedef enum logic [1:0] {
        RD_NONE = 2'b00,
        RD_CTRL = 2'b01,
        RD_CHAR = 2'b10
    } rd_sel_t;
    typedef enum logic [1:0] {
        MODE_LOCAL = 2'b00,
        MODE_REMOTE = 2'b01
    } mode_t;
endpackage

/* File: rtl/loop_device_cmd.sv */
/*
 * device-dependent command interpreter for a serial loop to rs-232 interface.
 * assumes one-cycle pulses from the loop decoder, one data byte per pulse.
 */
`timescale 1ns/1ps
`include "loop_cmd_map.svh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - listener code 0 stores up to 14 data bytes into control registers 0..13.
// - listener code 2 stores up to 12 data bytes into character registers 0..11.
// - listener code 3 clears transmit buffer and holds tx line low until break off.
// - listener code 4 clears transmit buffer and releases break.
// - talker code 0 makes next send-data return the 14 control registers.
// - talker code 2 makes next send-data return the 12 character registers.
// - write sequence stays armed until set full or next made listener.
// - readback stays selected until end-of-transmission, after last byte or not-ready.
// - local mode forwards data bytes unchanged to rs-232.
// - remote mode takes data bytes as instructions, never forwards them.
// - power-up and reset key select local mode.
// - remote enable only sets a flag; becoming listener enters remote.
// - go to local works only as listener and keeps the flag.
// - not remote enable forces local and clears the flag, in any state.
// - address state changes alone never leave remote mode.
// - device clear as listener empties buffers and restores register defaults.
// - control register readback byte is 0011 above the four-bit value.
module loop_device_cmd
    import loop_cmd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic key_reset,
    input wire logic is_listener,
    input wire logic is_talker,
    input wire logic became_listener,
    input wire logic ddl_valid,
    input wire logic [4:0] ddl_code,
    input wire logic ddt_valid,
    input wire logic [4:0] ddt_code,
    input wire logic cmd_remote_enable,
    input wire logic cmd_not_remote_enable,
    input wire logic cmd_go_to_local,
    input wire logic cmd_device_clear,
    input wire logic cmd_send_data,
    input wire logic cmd_not_ready,
    input wire logic data_valid,
    input wire logic [7:0] data_byte,
    input wire logic talk_next,
    input wire logic tx_serial,
    output logic tx_line,
    output logic fwd_valid,
    output logic [7:0] fwd_byte,
    output logic instr_valid,
    output logic [7:0] instr_byte,
    output logic tx_clear,
    output logic rx_clear,
    output logic rd_valid,
    output logic [7:0] rd_byte,
    output logic rd_eot,
    output logic remote_mode,
    output logic [3:0] first_control_register,
    output logic [3:0] last_control_register,
    output logic [7:0] first_character_register,
    output logic [7:0] last_character_register
);
    typedef struct packed {
        logic [13:0][3:0] ctrl;
        logic [11:0][7:0] chr;
        wr_sel_t wr;
        logic [4:0] wr_idx;
        rd_sel_t rd;
        logic rd_active;
        logic [4:0] rd_idx;
        logic brk;
        logic tx_line;
        logic fwd_valid;
        logic [7:0] fwd_byte;
        logic instr_valid;
        logic [7:0] instr_byte;
        logic tx_clear;
        logic rx_clear;
        logic rd_valid;
        logic [7:0] rd_byte;
        logic rd_eot;
        logic remote;
    } core_state_t;
    core_state_t st;
    core_state_t next_st;
    logic remote;

    function automatic logic [7:0] ctrl_byte(input logic [3:0] v);
        ctrl_byte = {`CTRL_READ_HI, v};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    remote_mode_fsm remote_mode_fsm_i (
        .clk(clk),
        .rst(rst),
        .key_reset(key_reset),
        .is_listener(is_listener),
        .became_listener(became_listener),
        .cmd_remote_enable(cmd_remote_enable),
        .cmd_not_remote_enable(cmd_not_remote_enable),
        .cmd_go_to_local(cmd_go_to_local),
        .remote(remote),
        .remote_enabled()
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        next_st.fwd_valid = 1'b0;
        next_st.instr_valid = 1'b0;
        next_st.tx_clear = 1'b0;
        next_st.rx_clear = 1'b0;
        next_st.rd_valid = 1'b0;
        next_st.rd_eot = 1'b0;
        next_st.remote = remote;
        if (became_listener) begin
            next_st.wr = WR_IDLE;
        end
        if (ddl_valid && is_listener) begin
            if (ddl_code == `DDL_SET_CTRL) begin
                next_st.wr = WR_CTRL;
                next_st.wr_idx = `IDX_ZERO;
            end else if (ddl_code == `DDL_CLR_TX) begin
                next_st.tx_clear = 1'b1;
            end else if (ddl_code == `DDL_SET_CHAR) begin
                next_st.wr = WR_CHAR;
                next_st.wr_idx = `IDX_ZERO;
            end else if (ddl_code == `DDL_BREAK_ON) begin
                next_st.tx_clear = 1'b1;
                next_st.brk = 1'b1;
            end else if (ddl_code == `DDL_BREAK_OFF) begin
                next_st.tx_clear = 1'b1;
                next_st.brk = 1'b0;
            end
        end
        if (ddt_valid && is_talker) begin
            if (ddt_code == `DDT_SEND_CTRL) begin
                next_st.rd = RD_CTRL;
                next_st.rd_active = 1'b0;
            end else if (ddt_code == `DDT_CLR_RX) begin
                next_st.rx_clear = 1'b1;
            end else if (ddt_code == `DDT_SEND_CHAR) begin
                next_st.rd = RD_CHAR;
                next_st.rd_active = 1'b0;
            end
        end
        if (data_valid && is_listener) begin
            if (st.wr == WR_CTRL) begin
                next_st.ctrl[st.wr_idx] = data_byte[3:0];
                next_st.wr_idx = st.wr_idx + `IDX_ONE;
                if (st.wr_idx == `LAST_CTRL) begin
                    next_st.wr = WR_IDLE;
                end
            end else if (st.wr == WR_CHAR) begin
                next_st.chr[st.wr_idx] = data_byte;
                next_st.wr_idx = st.wr_idx + `IDX_ONE;
                if (st.wr_idx == `LAST_CHAR) begin
                    next_st.wr = WR_IDLE;
                end
            end else if (remote) begin
                next_st.instr_valid = 1'b1;
                next_st.instr_byte = data_byte;
            end else begin
                next_st.fwd_valid = 1'b1;
                next_st.fwd_byte = data_byte;
            end
        end
        if (cmd_send_data && is_talker && st.rd != RD_NONE) begin
            next_st.rd_active = 1'b1;
            next_st.rd_idx = `IDX_ZERO;
        end else if (st.rd_active && cmd_not_ready) begin
            next_st.rd_eot = 1'b1;
            next_st.rd = RD_NONE;
            next_st.rd_active = 1'b0;
        end else if (st.rd_active && talk_next) begin
            if ((st.rd == RD_CTRL && st.rd_idx == `NUM_CTRL) ||
                (st.rd == RD_CHAR && st.rd_idx == `NUM_CHAR)) begin
                next_st.rd_eot = 1'b1;
                next_st.rd = RD_NONE;
                next_st.rd_active = 1'b0;
            end else begin
                next_st.rd_valid = 1'b1;
                next_st.rd_byte = (st.rd == RD_CTRL) ? ctrl_byte(st.ctrl[st.rd_idx])
                                                     : st.chr[st.rd_idx];
                next_st.rd_idx = st.rd_idx + `IDX_ONE;
            end
        end
        if (cmd_device_clear && is_listener) begin
            next_st.tx_clear = 1'b1;
            next_st.rx_clear = 1'b1;
            next_st.ctrl = {`NUM_CTRL{`CTRL_DEFAULT}};
            next_st.chr = {`NUM_CHAR{`CHAR_DEFAULT}};
        end
        next_st.tx_line = next_st.brk ? 1'b0 : tx_serial;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
            st.tx_line <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign tx_line = st.tx_line;
    assign fwd_valid = st.fwd_valid;
    assign fwd_byte = st.fwd_byte;
    assign instr_valid = st.instr_valid;
    assign instr_byte = st.instr_byte;
    assign tx_clear = st.tx_clear;
    assign rx_clear = st.rx_clear;
    assign rd_valid = st.rd_valid;
    assign rd_byte = st.rd_byte;
    assign rd_eot = st.rd_eot;
    assign remote_mode = st.remote;
    assign first_control_register = st.ctrl[`IDX_ZERO];
    assign last_control_register = st.ctrl[`LAST_CTRL];
    assign first_character_register = st.chr[`IDX_ZERO];
    assign last_character_register = st.chr[`LAST_CHAR];

    ////////////////////////////////////////////////////////////////////////////
    sequence s_break_on;
        ddl_valid && is_listener && ddl_code == `DDL_BREAK_ON;
    endsequence
    a_break_low: assert property (@(posedge clk) disable iff (rst)
        s_break_on |=> (tx_clear && !tx_line))
        else $error("break on did not clear and hold line low");
    a_break_off: assert property (@(posedge clk) disable iff (rst)
        (ddl_valid && is_listener && ddl_code == `DDL_BREAK_OFF && !cmd_device_clear)
        |=> tx_clear)
        else $error("break off did not clear transmit buffer");
    a_remote_nofwd: assert property (@(posedge clk) disable iff (rst)
        (data_valid && is_listener && remote && st.wr == WR_IDLE)
        |=> (!fwd_valid && instr_valid))
        else $error("remote data forwarded");
    a_local_fwd: assert property (@(posedge clk) disable iff (rst)
        (data_valid && is_listener && !remote && st.wr == WR_IDLE)
        |=> (fwd_valid && fwd_byte == $past(data_byte)))
        else $error("local data not forwarded");
    a_ctrl_readback: assert property (@(posedge clk) disable iff (rst)
        (rd_valid && $past(st.rd) == RD_CTRL) |-> rd_byte[7:4] == `CTRL_READ_HI)
        else $error("control readback upper nibble wrong");
    a_ctrl_write: assert property (@(posedge clk) disable iff (rst)
        (data_valid && is_listener && st.wr == WR_CTRL && !cmd_device_clear)
        |=> st.ctrl[$past(st.wr_idx)] == $past(data_byte[3:0]))
        else $error("control register write lost");
    a_dev_clear: assert property (@(posedge clk) disable iff (rst)
        (cmd_device_clear && is_listener) |=> (tx_clear && rx_clear && first_control_register
        == `CTRL_DEFAULT))
        else $error("device clear incomplete");
    a_not_ready_eot: assert property (@(posedge clk) disable iff (rst)
        (st.rd_active && cmd_not_ready && !(cmd_send_data && is_talker))
        |=> (rd_eot && st.rd == RD_NONE))
        else $error("not ready did not end readback");
endmodule // loop_device_cmd

/* File: rtl/remote_mode_fsm.sv */
/*
 * local and remote mode tracker with the remote-enabled flag.
 * assumes one-cycle command pulses from the loop decoder.
 */
`timescale 1ns/1ps
module remote_mode_fsm
    import loop_cmd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic key_reset,
    input wire logic is_listener,
    input wire logic became_listener,
    input wire logic cmd_remote_enable,
    input wire logic cmd_not_remote_enable,
    input wire logic cmd_go_to_local,
    output logic remote,
    output logic remote_enabled
);
    typedef struct packed {
        mode_t mode;
        logic ren;
    } fsm_state_t;
    fsm_state_t st;
    fsm_state_t next_st;
    always_comb begin
        next_st = st;
        if (cmd_remote_enable) begin
            next_st.ren = 1'b1;
        end
        case (st.mode)
            MODE_LOCAL: begin
                if (became_listener && (st.ren || cmd_remote_enable)) begin
                    next_st.mode = MODE_REMOTE;
                end
            end
            MODE_REMOTE: begin
                if (cmd_go_to_local && is_listener) begin
                    next_st.mode = MODE_LOCAL;
                end
            end
            default: next_st.mode = MODE_LOCAL;
        endcase
        if (cmd_not_remote_enable) begin
            next_st.mode = MODE_LOCAL;
            next_st.ren = 1'b0;
        end
        if (key_reset) begin
            next_st = '{mode: MODE_LOCAL, ren: 1'b0};
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '{mode: MODE_LOCAL, ren: 1'b0};
        end else begin
            st <= next_st;
        end
    end
    assign remote = (st.mode == MODE_REMOTE);
    assign remote_enabled = st.ren;

    a_ren_entry: assert property (@(posedge clk) disable iff (rst)
        (became_listener && st.ren && !cmd_not_remote_enable && !key_reset) |=> remote)
        else $error("listener with remote enabled did not enter remote");
    a_ren_only_path: assert property (@(posedge clk) disable iff (rst)
        (!remote && !became_listener) |=> !remote)
        else $error("remote entered without becoming listener");
    a_gtl_listener: assert property (@(posedge clk) disable iff (rst)
        (remote && cmd_go_to_local && !is_listener && !cmd_not_remote_enable && !key_reset)
        |=> remote)
        else $error("go to local obeyed while not a listener");
    a_gtl_keeps_ren: assert property (@(posedge clk) disable iff (rst)
        (cmd_go_to_local && remote_enabled && !cmd_not_remote_enable && !key_reset)
        |=> remote_enabled)
        else $error("go to local dropped remote enable");
    a_nre_local: assert property (@(posedge clk) disable iff (rst)
        cmd_not_remote_enable |=> (!remote && !remote_enabled))
        else $error("not remote enable ignored");
    a_key_local: assert property (@(posedge clk) disable iff (rst)
        key_reset |=> !remote)
        else $error("reset key left remote mode");
endmodule // remote_mode_fsm

/* File: tb/loop_ctrl_model.sv */
/*
 * loop controller model: drives address state, command pulses and data bytes.
 * assumes clk from the bench; pulses are set and cleared on falling edges.
 */
`timescale 1ns/1ps
module loop_ctrl_model (
    input wire logic clk,
    output logic is_listener,
    output logic is_talker,
    output logic became_listener,
    output logic ddl_valid,
    output logic [4:0] ddl_code,
    output logic ddt_valid,
    output logic [4:0] ddt_code,
    output logic cmd_remote_enable,
    output logic cmd_not_remote_enable,
    output logic cmd_go_to_local,
    output logic cmd_device_clear,
    output logic cmd_send_data,
    output logic cmd_not_ready,
    output logic data_valid,
    output logic [7:0] data_byte,
    output logic talk_next
);
    logic [9:0] p;
    assign {talk_next, data_valid, cmd_not_ready, cmd_send_data, cmd_device_clear,
        cmd_go_to_local, cmd_not_remote_enable, cmd_remote_enable, ddt_valid, ddl_valid} = p;
    initial begin
        p = '0;
        is_listener = 1'b0;
        is_talker = 1'b0;
        became_listener = 1'b0;
        ddl_code = 5'h1F;
        ddt_code = 5'h1F;
        data_byte = 8'hFF;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // one-cycle pulse of kind k; qualifiers hold inverted values once released
    task automatic pulse(input int k, input logic [7:0] v);
        @(negedge clk);
        ddl_code = v[4:0];
        ddt_code = v[4:0];
        data_byte = v;
        p[k] = 1'b1;
        @(negedge clk);
        p = '0;
        ddl_code = ~v[4:0];
        ddt_code = ~v[4:0];
        data_byte = ~v;
    endtask
    // addressing; a listen address always raises became_listener
    task automatic addr(input logic lis, input logic tlk);
        @(negedge clk);
        is_listener = lis;
        is_talker = tlk;
        became_listener = lis;
        @(negedge clk);
        became_listener = 1'b0;
    endtask
    // universal remote enable first, then this device's listen address
    task automatic go_remote();
        pulse(2, 8'h00);
        addr(1'b1, 1'b0);
    endtask
endmodule // loop_ctrl_model

/* File: tb/loop_device_cmd_tb.sv */
/*
 * self-checking bench for the loop device command interpreter.
 * assumes the design package and the loop controller model are compiled first.
 */
`timescale 1ns/1ps
module loop_device_cmd_tb;
    import loop_cmd_pkg::*;
    localparam int K_DDL = 0, K_DDT = 1, K_RE = 2, K_NRE = 3, K_GTL = 4, K_DC = 5;
    localparam int K_SD = 6, K_NR = 7, K_DATA = 8, K_TN = 9;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic key_reset = 1'b0;
    logic tx_serial = 1'b1;
    logic is_listener, is_talker, became_listener, ddl_valid, ddt_valid;
    logic [4:0] ddl_code, ddt_code;
    logic cmd_remote_enable, cmd_not_remote_enable, cmd_go_to_local, cmd_device_clear;
    logic cmd_send_data, cmd_not_ready, data_valid, talk_next;
    logic [7:0] data_byte, fwd_byte, instr_byte, rd_byte;
    logic tx_line, fwd_valid, instr_valid, tx_clear, rx_clear, rd_valid, rd_eot, remote_mode;
    logic [3:0] first_control_register, last_control_register;
    logic [7:0] first_character_register, last_character_register;
    int err_count = 0;
    int check_count = 0;
    always #12.5 clk = ~clk;
    loop_ctrl_model loop_ctrl_model_i (.clk(clk), .is_listener(is_listener),
        .is_talker(is_talker), .became_listener(became_listener), .ddl_valid(ddl_valid),
        .ddl_code(ddl_code), .ddt_valid(ddt_valid), .ddt_code(ddt_code),
        .cmd_remote_enable(cmd_remote_enable), .cmd_not_remote_enable(cmd_not_remote_enable),
        .cmd_go_to_local(cmd_go_to_local), .cmd_device_clear(cmd_device_clear),
        .cmd_send_data(cmd_send_data), .cmd_not_ready(cmd_not_ready),
        .data_valid(data_valid), .data_byte(data_byte), .talk_next(talk_next));
    loop_device_cmd loop_device_cmd_i (.clk(clk), .rst(rst), .key_reset(key_reset),
        .is_listener(is_listener), .is_talker(is_talker), .became_listener(became_listener),
        .ddl_valid(ddl_valid), .ddl_code(ddl_code), .ddt_valid(ddt_valid), .ddt_code(ddt_code),
        .cmd_remote_enable(cmd_remote_enable), .cmd_not_remote_enable(cmd_not_remote_enable),
        .cmd_go_to_local(cmd_go_to_local), .cmd_device_clear(cmd_device_clear),
        .cmd_send_data(cmd_send_data), .cmd_not_ready(cmd_not_ready),
        .data_valid(data_valid), .data_byte(data_byte), .talk_next(talk_next),
        .tx_serial(tx_serial), .tx_line(tx_line), .fwd_valid(fwd_valid), .fwd_byte(fwd_byte),
        .instr_valid(instr_valid), .instr_byte(instr_byte), .tx_clear(tx_clear),
        .rx_clear(rx_clear), .rd_valid(rd_valid), .rd_byte(rd_byte), .rd_eot(rd_eot),
        .remote_mode(remote_mode), .first_control_register(first_control_register),
        .last_control_register(last_control_register),
        .first_character_register(first_character_register),
        .last_character_register(last_character_register));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic pl(input int k, input logic [7:0] v);
        loop_ctrl_model_i.pulse(k, v);
    endtask
    task automatic ad(input logic lis, input logic tlk);
        loop_ctrl_model_i.addr(lis, tlk);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_write();
        ad(1'b1, 1'b0);
        pl(K_DDL, 8'h00);
        for (logic [7:0] b = 8'h00; b < 8'h0E; b++) begin
            pl(K_DATA, 8'hA0 | b);
            chk("fwd_valid armed", {7'h00, fwd_valid}, 8'h00);
        end
        chk("first ctrl", {4'h0, first_control_register}, 8'h00);
        chk("last ctrl", {4'h0, last_control_register}, 8'h0D);
        pl(K_DATA, 8'h3C);
        chk("fwd_valid full", {7'h00, fwd_valid}, 8'h01);
        chk("fwd_byte", fwd_byte, 8'h3C);
        pl(K_DDL, 8'h02);
        for (logic [7:0] b = 8'h00; b < 8'h03; b++) pl(K_DATA, 8'h90 | b);
        chk("first char", first_character_register, 8'h90);
        ad(1'b1, 1'b0);
        pl(K_DATA, 8'h77);
        chk("fwd after relisten", {7'h00, fwd_valid}, 8'h01);
        pl(K_DDL, 8'h02);
        for (logic [7:0] b = 8'h00; b < 8'h0C; b++) pl(K_DATA, 8'hC0 | b);
        chk("first char", first_character_register, 8'hC0);
        chk("last char", last_character_register, 8'hCB);
    endtask
    task automatic t_read();
        ad(1'b0, 1'b1);
        pl(K_DDT, 8'h00);
        pl(K_SD, 8'h00);
        for (logic [7:0] b = 8'h00; b < 8'h0E; b++) begin
            pl(K_TN, 8'h00);
            chk("rd_valid", {7'h00, rd_valid}, 8'h01);
            chk("rd_byte ctrl", rd_byte, 8'h30 | b);
        end
        pl(K_TN, 8'h00);
        chk("rd_eot last", {7'h00, rd_eot}, 8'h01);
        pl(K_SD, 8'h00);
        pl(K_TN, 8'h00);
        chk("rd_valid unselected", {7'h00, rd_valid}, 8'h00);
        pl(K_DDT, 8'h02);
        pl(K_SD, 8'h00);
        for (logic [7:0] b = 8'h00; b < 8'h03; b++) begin
            pl(K_TN, 8'h00);
            chk("rd_byte char", rd_byte, 8'hC0 | b);
        end
        pl(K_NR, 8'h00);
        chk("rd_eot not ready", {7'h00, rd_eot}, 8'h01);
    endtask
    task automatic t_break_clear();
        ad(1'b1, 1'b0);
        pl(K_DDL, 8'h03);
        chk("tx_clear on", {7'h00, tx_clear}, 8'h01);
        cyc(3);
        chk("tx_line break", {7'h00, tx_line}, 8'h00);
        pl(K_DDL, 8'h04);
        chk("tx_clear off", {7'h00, tx_clear}, 8'h01);
        cyc(1);
        chk("tx_line idle", {7'h00, tx_line}, 8'h01);
        tx_serial = 1'b0;
        cyc(2);
        chk("tx_line data", {7'h00, tx_line}, 8'h00);
        tx_serial = 1'b1;
        pl(K_DDL, 8'h01);
        chk("tx_clear code1", {7'h00, tx_clear}, 8'h01);
        pl(K_DDL, 8'h07);
        chk("tx_clear code7", {7'h00, tx_clear}, 8'h00);
        ad(1'b0, 1'b1);
        pl(K_DDT, 8'h01);
        chk("rx_clear code1", {7'h00, rx_clear}, 8'h01);
        pl(K_DDL, 8'h01);
        chk("tx_clear talker", {7'h00, tx_clear}, 8'h00);
    endtask
    task automatic t_remote();
        ad(1'b0, 1'b0);
        pl(K_RE, 8'h00);
        cyc(2);
        chk("remote flag only", {7'h00, remote_mode}, 8'h00);
        ad(1'b1, 1'b0);
        cyc(2);
        chk("remote entered", {7'h00, remote_mode}, 8'h01);
        pl(K_DATA, 8'h5A);
        chk("instr_valid", {7'h00, instr_valid}, 8'h01);
        chk("instr_byte", instr_byte, 8'h5A);
        chk("fwd remote", {7'h00, fwd_valid}, 8'h00);
        ad(1'b0, 1'b1);
        ad(1'b0, 1'b0);
        pl(K_GTL, 8'h00);
        cyc(2);
        chk("remote idle", {7'h00, remote_mode}, 8'h01);
        ad(1'b1, 1'b0);
        pl(K_GTL, 8'h00);
        cyc(2);
        chk("local by gtl", {7'h00, remote_mode}, 8'h00);
        ad(1'b1, 1'b0);
        cyc(2);
        chk("remote again", {7'h00, remote_mode}, 8'h01);
        ad(1'b0, 1'b1);
        pl(K_NRE, 8'h00);
        cyc(2);
        chk("local by nre", {7'h00, remote_mode}, 8'h00);
        ad(1'b1, 1'b0);
        cyc(2);
        chk("flag cleared", {7'h00, remote_mode}, 8'h00);
        loop_ctrl_model_i.go_remote();
        cyc(2);
        chk("remote via model", {7'h00, remote_mode}, 8'h01);
        @(negedge clk);
        key_reset = 1'b1;
        @(negedge clk);
        key_reset = 1'b0;
        cyc(2);
        chk("local by key", {7'h00, remote_mode}, 8'h00);
    endtask
    task automatic t_dev_clear();
        ad(1'b1, 1'b0);
        pl(K_DC, 8'h00);
        chk("dc tx_clear", {7'h00, tx_clear}, 8'h01);
        chk("dc rx_clear", {7'h00, rx_clear}, 8'h01);
        cyc(1);
        chk("dc last ctrl", {4'h0, last_control_register}, 8'h00);
        chk("dc last char", last_character_register, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        chk("tx_line reset", {7'h00, tx_line}, 8'h01);
        chk("remote reset", {7'h00, remote_mode}, 8'h00);
        t_write();
        t_read();
        t_break_clear();
        t_remote();
        t_dev_clear();
        test_done();
    end
    initial begin
        #100000;
        err_count++;
        test_done();
    end
endmodule // loop_device_cmd_tb
